/* File: rtl/periodic_timer_core.sv */
// Periodic timer core: counter, two comparators, capture and pin output.
// Assumes an APB master on ref_clk and pins synchronous to ref_clk.
// How it works
// - Ten-bit up-counter advanced by a selectable internal or external clock.
// - Comparators A and P compare their values with every counter bit.
// - Software changes the counter only by a rising run enable.
// - Counter clears on overflow or its comparator match, raising a flag; single pulse PWM never clears on match.
// - Pause holds the count unless a rising run or a capture edge clear zeroes it; clearing pause resumes from the held value.
// - Clock select: sys/4, sys, h/16, h/64, sub, sub, pin rise, pin fall.
// - Run enable set lets the counter run; cleared stops it.
// - Rising run clears the counter; falling run keeps the residual value.
// - Rising run returns the output to its initial level in compare mode.
// - Low three bits of control register zero read as zero.
// - Mode field: compare, capture, PWM or single pulse, timer.
// - Timer mode leaves the output pin undefined; it is released here.
// - Compare mode A match: keep, drive low, drive high, toggle.
// - PWM mode pin function: inactive, active, PWM wave, single pulse.
// - Counter pair read only; A, period and B pairs read and write.
// - Control register two and B pair exist only in instance zero.
// - Capture input chosen between external pin and internal comparator.
// - Clear source in compare and timer modes: one clears on A, zero on P or overflow.
// - Output level bit: initial level in compare, polarity in PWM.
// - Invert bit flips the output waveform, no effect in timer mode.
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_core #(
  parameter int CNT_WIDTH = timer_pkg::CNT_WIDTH,
  parameter bit HAS_B = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subClockTick,
  input wire logic extClockPin,
  input wire logic captureInput,
  input wire logic internalComparatorSignal,
  output logic timerOutputPin,
  output logic timerOutputEn,
  output logic periodMatchFlag,
  output logic aMatchFlag
);
  import timer_pkg::*;

  localparam int HI = CNT_WIDTH - 8;

  generate
    if (CNT_WIDTH < 9 || CNT_WIDTH > 16) begin : g_bad_width
      $error("periodic_timer_core needs CNT_WIDTH from 9 to 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl0_next;
  logic [7:0] ctrl1_reg;
  logic [1:0] capClr_reg;
  logic edgeFlag_reg;
  logic inSel_reg;
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] aVal_reg;
  logic [CNT_WIDTH-1:0] bVal_reg;
  logic [CNT_WIDTH-1:0] pVal_reg;
  logic runPrev_reg;
  logic extPrev_reg;
  logic capPrev_reg;
  logic pFlag_reg;
  logic aFlag_reg;
  logic outLevel_reg;
  logic pin_reg;
  logic [31:0] prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control fields
  logic pause;
  logic run;
  logic [2:0] clkSel;
  logic [1:0] mode;
  logic [1:0] pinFn;
  logic olc;
  logic inv;
  logic capSrc;
  logic clrSrc;

  assign pause = ctrl0_reg[CTRL0_PAUSE_BIT];
  assign clkSel = ctrl0_reg[CTRL0_CLK_LSB +: 3];
  assign run = ctrl0_reg[CTRL0_RUN_BIT];
  assign mode = ctrl1_reg[CTRL1_MODE_LSB +: 2];
  assign pinFn = ctrl1_reg[CTRL1_PIN_LSB +: 2];
  assign olc = ctrl1_reg[CTRL1_OLC_BIT];
  assign inv = ctrl1_reg[CTRL1_INV_BIT];
  assign capSrc = ctrl1_reg[CTRL1_CAPSRC_BIT];
  assign clrSrc = ctrl1_reg[CTRL1_CLRSRC_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Clock source ticks
  logic tick4;
  logic tick16;
  logic tick64;
  logic srcTick;
  logic extRise;
  logic extFall;

  tick_divider #(.DIV(DIV_SYS4)) u_div4 (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .tick(tick4));
  tick_divider #(.DIV(DIV_H16)) u_div16 (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .tick(tick16));
  tick_divider #(.DIV(DIV_H64)) u_div64 (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .tick(tick64));

  assign extRise = extClockPin && !extPrev_reg;
  assign extFall = !extClockPin && extPrev_reg;

  always_comb begin
    case (clkSel)
      CLK_SYS4: srcTick = tick4;
      CLK_SYS: srcTick = 1'b1;
      CLK_H16: srcTick = tick16;
      CLK_H64: srcTick = tick64;
      CLK_SUB0, CLK_SUB1: srcTick = subClockTick;
      CLK_EXT_RISE: srcTick = extRise;
      CLK_EXT_FALL: srcTick = extFall;
      default: srcTick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparators and capture edges
  logic runRise;
  logic singlePulse;
  logic countEn;
  logic pMatch;
  logic aMatch;
  logic capSig;
  logic capRise;
  logic capFall;
  logic capActive;
  logic capRiseHit;
  logic capFallHit;
  logic useB;
  logic latchA;
  logic latchB;
  logic edgeClr;
  logic counterClear;

  assign runRise = run && !runPrev_reg;
  assign singlePulse = (mode == MODE_PWM) && (pinFn == PWM_SINGLE);
  assign countEn = clkEn && run && !pause && srcTick && !runRise;
  assign pMatch = countEn && ((pVal_reg == '0) ? (cnt_reg == '1) : (cnt_reg == pVal_reg));
  assign aMatch = countEn && (cnt_reg == aVal_reg);

  assign capSig = capSrc ? extClockPin : (inSel_reg ? internalComparatorSignal : captureInput);
  assign capRise = capSig && !capPrev_reg;
  assign capFall = !capSig && capPrev_reg;
  assign capActive = clkEn && run && (mode == MODE_CAPTURE);
  assign capRiseHit = capActive && capRise && (pinFn == CAP_RISE || pinFn == CAP_BOTH);
  assign capFallHit = capActive && capFall && (pinFn == CAP_FALL || pinFn == CAP_BOTH);
  assign useB = HAS_B && (capClr_reg != CAPCLR_NONE);
  assign latchB = capRiseHit && useB;
  assign latchA = capFallHit || (capRiseHit && !useB);
  assign edgeClr = useB && capActive && ((capClr_reg == CAPCLR_RISE && capRise)
                   || (capClr_reg == CAPCLR_FALL && capFall) || (capClr_reg == CAPCLR_BOTH && (capRise || capFall)));

  always_comb begin
    case (mode)
      MODE_CAPTURE: counterClear = pMatch || edgeClr;
      MODE_PWM: counterClear = singlePulse ? 1'b0 : pMatch;
      MODE_COMPARE, MODE_TIMER: counterClear = clrSrc ? aMatch : pMatch;
      default: counterClear = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (clkEn) begin
      if (runRise) begin
        cnt_reg <= '0;
      end else if (counterClear) begin
        cnt_reg <= '0;
      end else if (countEn) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      runPrev_reg <= 1'b0;
      extPrev_reg <= 1'b0;
      capPrev_reg <= 1'b0;
    end else if (clkEn) begin
      runPrev_reg <= run;
      extPrev_reg <= extClockPin;
      capPrev_reg <= capSig;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic access;
  logic wr;
  logic hit;
  logic [31:0] readMux;

  assign access = psel && penable && clkEn;
  assign wr = access && pwrite;
  assign pready = clkEn;

  always_comb begin
    case (paddr)
      OFF_CTRL0, OFF_CTRL1, OFF_COUNT_LOW, OFF_COUNT_HIGH, OFF_MATCH_A_LOW, OFF_MATCH_A_HIGH,
      OFF_PERIOD_LOW, OFF_PERIOD_HIGH, OFF_INPUT_SEL, OFF_FLAGS: hit = 1'b1;
      OFF_CTRL2, OFF_MATCH_B_LOW, OFF_MATCH_B_HIGH: hit = HAS_B;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !hit;

  always_comb begin
    readMux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL0: readMux[7:0] = {ctrl0_reg[7:CTRL0_IMPL_LSB], 3'h0};
      OFF_CTRL1: readMux[7:0] = ctrl1_reg;
      OFF_CTRL2: readMux[2:0] = HAS_B ? {capClr_reg, edgeFlag_reg} : 3'h0;
      OFF_COUNT_LOW: readMux[7:0] = cnt_reg[7:0];
      OFF_COUNT_HIGH: readMux[HI-1:0] = cnt_reg[CNT_WIDTH-1:8];
      OFF_MATCH_A_LOW: readMux[7:0] = aVal_reg[7:0];
      OFF_MATCH_A_HIGH: readMux[HI-1:0] = aVal_reg[CNT_WIDTH-1:8];
      OFF_MATCH_B_LOW: readMux[7:0] = HAS_B ? bVal_reg[7:0] : 8'h00;
      OFF_MATCH_B_HIGH: readMux[HI-1:0] = HAS_B ? bVal_reg[CNT_WIDTH-1:8] : '0;
      OFF_PERIOD_LOW: readMux[7:0] = pVal_reg[7:0];
      OFF_PERIOD_HIGH: readMux[HI-1:0] = pVal_reg[CNT_WIDTH-1:8];
      OFF_INPUT_SEL: readMux[0] = inSel_reg;
      OFF_FLAGS: readMux[1:0] = {aFlag_reg, pFlag_reg};
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      prdata_reg <= readMux;
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_comb begin
    ctrl0_next = ctrl0_reg;
    if (wr && paddr == OFF_CTRL0) begin
      ctrl0_next = {pwdata[7:CTRL0_IMPL_LSB], 3'h0};
    end else if (singlePulse && aMatch) begin
      ctrl0_next[CTRL0_RUN_BIT] = 1'b0;
    end
    if (clkEn && singlePulse && extRise) begin
      ctrl0_next[CTRL0_RUN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl0_reg <= CTRL0_RESET;
    end else if (clkEn) begin
      ctrl0_reg <= ctrl0_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg <= CTRL1_RESET;
      inSel_reg <= 1'b0;
      capClr_reg <= CAPCLR_RESET;
    end else if (wr) begin
      if (paddr == OFF_CTRL1) begin
        ctrl1_reg <= pwdata[7:0];
      end
      if (paddr == OFF_INPUT_SEL) begin
        inSel_reg <= pwdata[0];
      end
      if (HAS_B && paddr == OFF_CTRL2) begin
        capClr_reg <= pwdata[CTRL2_CAPCLR_LSB +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edgeFlag_reg <= 1'b0;
    end else if (latchB) begin
      edgeFlag_reg <= 1'b1;
    end else if (latchA && useB) begin
      edgeFlag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match values, capture wins over a write in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aVal_reg <= VALUE_RESET[CNT_WIDTH-1:0];
      bVal_reg <= VALUE_RESET[CNT_WIDTH-1:0];
      pVal_reg <= VALUE_RESET[CNT_WIDTH-1:0];
    end else begin
      if (latchA) begin
        aVal_reg <= cnt_reg;
      end else if (wr && paddr == OFF_MATCH_A_LOW) begin
        aVal_reg[7:0] <= pwdata[7:0];
      end else if (wr && paddr == OFF_MATCH_A_HIGH) begin
        aVal_reg[CNT_WIDTH-1:8] <= pwdata[HI-1:0];
      end
      if (latchB) begin
        bVal_reg <= cnt_reg;
      end else if (HAS_B && wr && paddr == OFF_MATCH_B_LOW) begin
        bVal_reg[7:0] <= pwdata[7:0];
      end else if (HAS_B && wr && paddr == OFF_MATCH_B_HIGH) begin
        bVal_reg[CNT_WIDTH-1:8] <= pwdata[HI-1:0];
      end
      if (wr && paddr == OFF_PERIOD_LOW) begin
        pVal_reg[7:0] <= pwdata[7:0];
      end else if (wr && paddr == OFF_PERIOD_HIGH) begin
        pVal_reg[CNT_WIDTH-1:8] <= pwdata[HI-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match flags, a set beats a write-one clear
  logic pSet;
  logic aSet;
  logic flagWr;

  assign pSet = pMatch;
  assign aSet = (mode == MODE_CAPTURE) ? (latchA || latchB) : aMatch;
  assign flagWr = wr && (paddr == OFF_FLAGS);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pFlag_reg <= 1'b0;
      aFlag_reg <= 1'b0;
    end else begin
      pFlag_reg <= pSet || (pFlag_reg && !(flagWr && pwdata[FLAG_P_BIT]));
      aFlag_reg <= aSet || (aFlag_reg && !(flagWr && pwdata[FLAG_A_BIT]));
    end
  end

  assign periodMatchFlag = pFlag_reg;
  assign aMatchFlag = aFlag_reg;

  ////////////////////////////////////////////////////////////////////////
  // Output pin
  logic level;
  logic pinNext;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outLevel_reg <= 1'b0;
    end else if (clkEn) begin
      if (runRise) begin
        outLevel_reg <= olc;
      end else if (aMatch && mode == MODE_COMPARE) begin
        case (pinFn)
          PIN_LOW: outLevel_reg <= 1'b0;
          PIN_HIGH: outLevel_reg <= 1'b1;
          PIN_TOGGLE: outLevel_reg <= !outLevel_reg;
          default: outLevel_reg <= outLevel_reg;
        endcase
      end
    end
  end

  always_comb begin
    case (mode)
      MODE_COMPARE: level = outLevel_reg;
      MODE_PWM: begin
        case (pinFn)
          PWM_INACTIVE: level = !olc;
          PWM_ACTIVE: level = olc;
          PWM_WAVE: level = (cnt_reg < aVal_reg) ? olc : !olc;
          PWM_SINGLE: level = run ? olc : !olc;
          default: level = 1'b0;
        endcase
      end
      default: level = 1'b0;
    endcase
  end

  assign pinNext = level ^ inv;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_reg <= 1'b0;
    end else if (clkEn) begin
      pin_reg <= pinNext;
    end
  end

  assign timerOutputPin = pin_reg;
  assign timerOutputEn = (mode == MODE_COMPARE) || (mode == MODE_PWM);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_run_rise_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    clkEn && runRise |=> cnt_reg == '0) else $error("counter not cleared on run rise");
  a_pause_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    clkEn && pause && !runRise && !edgeClr |=> $stable(cnt_reg)) else $error("paused counter moved");
  a_off_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    !run && !edgeClr |=> $stable(cnt_reg)) else $error("stopped counter moved");
  a_count_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    countEn && !counterClear |=> cnt_reg == $past(cnt_reg) + 1'b1) else $error("counter step wrong");
  a_match_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    counterClear && clkEn ##1 1'b1 |-> cnt_reg == '0 && (pFlag_reg || aFlag_reg || $past(edgeClr)))
    else $error("match did not clear counter");
  a_a_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    aMatch && mode != MODE_CAPTURE |=> aFlag_reg) else $error("A flag missed");
  a_ctrl0_low_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    clkEn && psel && !penable && !pwrite && paddr == OFF_CTRL0 |=> prdata[2:0] == 3'h0)
    else $error("unimplemented bits read nonzero");
  a_init_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    clkEn && runRise && mode == MODE_COMPARE |=> outLevel_reg == $past(olc) ##1 timerOutputPin == ($past(olc, 2) ^ $past(inv)))
    else $error("output not returned to initial level");
  a_cmp_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
    aMatch && mode == MODE_COMPARE && pinFn == PIN_TOGGLE |=> outLevel_reg != $past(outLevel_reg))
    else $error("compare toggle missed");
  a_timer_pin_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_TIMER |-> !timerOutputEn) else $error("pin driven in timer mode");
  a_capture_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
    latchA |=> aVal_reg == $past(cnt_reg)) else $error("capture did not latch count");
endmodule
`default_nettype wire

/* File: pkg/timer_pkg.sv */
// Constants shared by the periodic timer core and its helper modules.
// Assumes a 32-bit APB register bus; each byte register takes one word.
package timer_pkg;

  localparam int CNT_WIDTH = 10;
  localparam int ADDR_WIDTH = 8;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h0C;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h10;
  localparam logic [7:0] OFF_MATCH_A_LOW = 8'h14;
  localparam logic [7:0] OFF_MATCH_A_HIGH = 8'h18;
  localparam logic [7:0] OFF_MATCH_B_LOW = 8'h1C;
  localparam logic [7:0] OFF_MATCH_B_HIGH = 8'h20;
  localparam logic [7:0] OFF_PERIOD_LOW = 8'h24;
  localparam logic [7:0] OFF_PERIOD_HIGH = 8'h28;
  localparam logic [7:0] OFF_INPUT_SEL = 8'h2C;
  localparam logic [7:0] OFF_FLAGS = 8'h30;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL0_PAUSE_BIT = 7;
  localparam int CTRL0_CLK_LSB = 4;
  localparam int CTRL0_RUN_BIT = 3;
  localparam int CTRL0_IMPL_LSB = 3;
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_PIN_LSB = 4;
  localparam int CTRL1_OLC_BIT = 3;
  localparam int CTRL1_INV_BIT = 2;
  localparam int CTRL1_CAPSRC_BIT = 1;
  localparam int CTRL1_CLRSRC_BIT = 0;
  localparam int CTRL2_CAPCLR_LSB = 1;
  localparam int CTRL2_EDGE_BIT = 0;
  localparam int FLAG_P_BIT = 0;
  localparam int FLAG_A_BIT = 1;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [1:0] CAPCLR_RESET = 2'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [2:0] CLK_SYS4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_H16 = 3'h2;
  localparam logic [2:0] CLK_H64 = 3'h3;
  localparam logic [2:0] CLK_SUB0 = 3'h4;
  localparam logic [2:0] CLK_SUB1 = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  localparam logic [1:0] PIN_KEEP = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [1:0] PIN_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAPCLR_NONE = 2'h0;
  localparam logic [1:0] CAPCLR_RISE = 2'h1;
  localparam logic [1:0] CAPCLR_FALL = 2'h2;
  localparam logic [1:0] CAPCLR_BOTH = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Divide ratios of the internal clock taps
  localparam int DIV_SYS4 = 4;
  localparam int DIV_H16 = 16;
  localparam int DIV_H64 = 64;

endpackage

/* File: rtl/tick_divider.sv */
// Divides the system clock into a one-cycle tick every DIV enabled cycles.
// Assumes clkEn freezes it together with the rest of the timer.
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_reg;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("tick_divider needs DIV of at least 2");
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (clkEn) begin
      cnt_reg <= (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
    end
  end

  assign tick = clkEn && (cnt_reg == W'(DIV - 1));
endmodule
`default_nettype wire

/* File: verif/periodic_timer_core_tb.sv */
// Self-checking testbench for the periodic timer core over APB.
// Assumes timer_pkg is compiled first and one 100 MHz clock drives all.
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_core_tb;
  import timer_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, c1, c2;
  logic [31:0] rnd = 32'h5F27;
  logic pready, pslverr, pin, pinEn, pFlag, aFlag;
  logic [2:0] ph = 3'h0;
  logic subTick = 1'h0;
  logic extPin = 1'h0;
  logic [32:0] expQ[$];
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int dv[8] = '{16, 66, 4, 1, 8, 8, 8, 8};
  always #5 ref_clk = ~ref_clk;
  periodic_timer_core dut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .subClockTick(subTick), .extClockPin(extPin), .captureInput(1'b0), .internalComparatorSignal(extPin),
    .timerOutputPin(pin), .timerOutputEn(pinEn), .periodMatchFlag(pFlag), .aMatchFlag(aFlag));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input logic [31:0] v, input int e);
    check(what, {32'h0, (v + 32'h3 >= 32'(e)) && (v <= 32'(e + 3))}, 33'h1);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdq(input logic [7:0] a, input logic [32:0] exp);
    expQ.push_back(exp);
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Read monitor: oldest note against each completed read
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && expQ.size() > 0) begin
      check("read", {pslverr, prdata}, expQ.pop_front());
    end
  end
  // Sub clock pulse and pin clock, one period every 8 cycles
  always @(posedge ref_clk) begin
    ph <= ph + 3'h1;
    subTick <= (ph == 3'h7);
    extPin <= ph[2];
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'h1;
    rdq(OFF_CTRL0, 33'h0);
    rdq(OFF_CTRL1, 33'h0);
    rdq(OFF_COUNT_LOW, 33'h0);
    rdq(8'h3C, 33'h1_0000_0000);
    rnd = xs(rnd);
    xfer(1'h1, OFF_MATCH_A_LOW, rnd);
    rdq(OFF_MATCH_A_LOW, {25'h0, rnd[7:0]});
    xfer(1'h1, OFF_PERIOD_HIGH, rnd >> 8);
    rdq(OFF_PERIOD_HIGH, {31'h0, rnd[9:8]});
    xfer(1'h1, OFF_PERIOD_HIGH, 32'h0);
    xfer(1'h1, OFF_CTRL0, rnd);
    rdq(OFF_CTRL0, {25'h0, rnd[7:3], 3'h0});
    $display("test registers done");
    xfer(1'h1, OFF_CTRL0, 32'h0);
    xfer(1'h1, OFF_CTRL1, {24'h0, MODE_TIMER, 6'h0});
    @(posedge ref_clk);
    check("pin enable", {32'h0, pinEn}, 33'h0);
    for (int s = 0; s < 8; s++) begin
      xfer(1'h1, OFF_CTRL0, {24'h0, 1'h0, 3'(s), 4'h8});
      repeat (64) @(posedge ref_clk);
      xfer(1'h1, OFF_CTRL0, {24'h0, 1'h0, 3'(s), 4'h0});
      xfer(1'h0, OFF_COUNT_LOW, 32'h0);
      near("count rate", rd, dv[s]);
    end
    $display("test clock select done");
    xfer(1'h1, OFF_CTRL0, 32'h18);
    repeat (20) @(posedge ref_clk);
    xfer(1'h1, OFF_CTRL0, 32'h98);
    xfer(1'h0, OFF_COUNT_LOW, 32'h0);
    c1 = rd;
    repeat (10) @(posedge ref_clk);
    rdq(OFF_COUNT_LOW, {1'h0, c1});
    xfer(1'h1, OFF_CTRL0, 32'h18);
    repeat (10) @(posedge ref_clk);
    xfer(1'h0, OFF_COUNT_LOW, 32'h0);
    check("resume", {32'h0, rd > c1}, 33'h1);
    xfer(1'h1, OFF_CTRL0, 32'h10);
    xfer(1'h0, OFF_COUNT_LOW, 32'h0);
    c2 = rd;
    rnd = xs(rnd);
    xfer(1'h1, OFF_COUNT_LOW, rnd);
    rdq(OFF_COUNT_LOW, {1'h0, c2});
    $display("test pause and residual done");
    xfer(1'h1, OFF_MATCH_A_LOW, 32'h14);
    xfer(1'h1, OFF_MATCH_A_HIGH, 32'h0);
    for (int f = 0; f < 4; f++) begin
      xfer(1'h1, OFF_CTRL0, 32'h0);
      xfer(1'h1, OFF_CTRL1, {24'h0, MODE_COMPARE, 2'(f), f != 2, 3'h1});
      xfer(1'h1, OFF_CTRL0, 32'h18);
      repeat (3) @(posedge ref_clk);
      check("initial pin", {32'h0, pin}, {32'h0, f != 2});
      repeat (30) @(posedge ref_clk);
      check("match pin", {32'h0, pin}, {32'h0, !f[0]});
      check("a flag", {32'h0, aFlag}, 33'h1);
      xfer(1'h1, OFF_CTRL0, 32'h0);
      xfer(1'h0, OFF_COUNT_LOW, 32'h0);
      check("clear on a", {32'h0, rd <= 32'h14}, 33'h1);
      xfer(1'h1, OFF_FLAGS, 32'h3);
      rdq(OFF_FLAGS, 33'h0);
    end
    $display("test compare done");
    xfer(1'h1, OFF_CTRL1, {24'h0, MODE_CAPTURE, 6'h0});
    xfer(1'h1, OFF_CTRL0, 32'h18);
    for (int i = 1; i >= 0; i--) begin
      xfer(1'h1, OFF_INPUT_SEL, 32'(i));
      repeat (16) @(posedge ref_clk);
      xfer(1'h0, OFF_MATCH_A_LOW, 32'h0);
      c1 = rd;
      repeat (13) @(posedge ref_clk);
      xfer(1'h0, OFF_MATCH_A_LOW, 32'h0);
      check("capture step", {25'h0, 8'(rd - c1)}, {28'h0, 1'(i), 4'h0});
    end
    $display("test capture done");
    xfer(1'h1, OFF_CTRL0, 32'h0);
    xfer(1'h1, OFF_PERIOD_LOW, 32'h10);
    xfer(1'h1, OFF_CTRL1, 32'h0);
    xfer(1'h1, OFF_CTRL0, 32'h18);
    repeat (40) @(posedge ref_clk);
    check("p flag", {32'h0, pFlag}, 33'h1);
    xfer(1'h1, OFF_CTRL0, 32'h0);
    xfer(1'h0, OFF_COUNT_LOW, 32'h0);
    check("clear on p", {32'h0, rd <= 32'h10}, 33'h1);
    $display("test period done");
    for (int k = 0; k < 8; k++) begin
      xfer(1'h1, OFF_CTRL0, 32'h0);
      xfer(1'h1, OFF_CTRL1, {24'h0, MODE_PWM, 1'h0, 3'(k), 2'h0});
      xfer(1'h1, OFF_CTRL0, 32'h18);
      repeat (3) @(posedge ref_clk);
      check("forced pin", {32'h0, pin}, {32'h0, (k[2] ? k[1] : !k[1]) ^ k[0]});
      check("pin enable", {32'h0, pinEn}, 33'h1);
    end
    $display("test pwm force done");
    summarize();
  end
endmodule
`default_nettype wire
